// >>> design/bsc_exec.sv
`timescale 1ns/1ns
`include "bsc_map.svh"
module bsc_exec
    import bsc_pkg::*;
(
    input wire logic CLK, // 20 MHz core clock
    input wire logic RESETN, // Async reset, active low
    input wire logic [13:0] INSTR, // Fetched instruction word
    input wire logic [7:0] REG_DATA, // Register file read data
    input wire logic [7:0] PC_HIGH_LATCH, // pc_high_latch contents
    output logic [12:0] PC, // Program counter
    output logic [6:0] REG_ADDR, // Register file read address
    output logic STACK_PUSH, // Push pulse to stack_top
    output logic [12:0] STACK_DATA, // Return address pushed
    output logic EXEC_NOP, // Current cycle executes as no-op
    output logic CYCLE_END // Instruction cycle boundary pulse
);
    bsc_phase_if ph ();
    bsc_state_t state_q;
    logic [13:0] ir_q;
    logic [12:0] pc_q;
    logic [6:0] addr_q;
    logic push_q;
    logic [12:0] push_data_q;
    logic nop_q;
    logic end_q;
    logic bit_hit;
    logic exec_now;
    logic two_cycle;
    bsc_op_t op;

    bsc_phase u_phase (
        .clk(CLK),
        .resetn(RESETN),
        .ph(ph.gen)
    );

    // Opcode class of a latched word
    function automatic bsc_op_t decode(input logic [13:0] w);
        bsc_op_t kind;
        kind = BSC_OP_OTHER;
        if (w[`BSC_OPC4_HI:`BSC_OPC4_LO] == `BSC_BTSS_PAT) begin
            kind = BSC_OP_SKIP;
        end else if (w[`BSC_OPC4_HI:`BSC_OPC3_LO] == `BSC_CALL_PAT) begin
            kind = BSC_OP_CALL;
        end
        return kind;
    endfunction

    // Bit number tested by a skip
    function automatic logic [2:0] bit_index(input logic [13:0] w);
        return w[`BSC_BIT_HI:`BSC_BIT_LO];
    endfunction

    // Register address field of a word
    function automatic logic [6:0] reg_field(input logic [13:0] w);
        return w[`BSC_FADR_HI:0];
    endfunction

    // Call target: latch page bits above the literal
    function automatic logic [12:0] call_target(
        input logic [13:0] w,
        input logic [7:0] latch
    );
        return {latch[`BSC_PAGE_HI:`BSC_PAGE_LO], w[`BSC_LIT_HI:0]};
    endfunction

    // Sequential successor of a counter value
    function automatic logic [12:0] pc_next(input logic [12:0] p);
        return p + `BSC_PC_ONE;
    endfunction

    // Word needs a second, idle cycle
    function automatic logic needs_flush(input bsc_op_t k, input logic hit);
        return (k == BSC_OP_SKIP && hit) || k == BSC_OP_CALL;
    endfunction

    assign op = decode(ir_q);
    assign bit_hit = REG_DATA[bit_index(ir_q)];
    // Flushed slot never starts a second flush
    assign exec_now = (state_q == BSC_EXEC);
    assign two_cycle = exec_now && needs_flush(op, bit_hit);

    // Instruction latch, loaded every Q4 (flushed slot too); reset loads a no-op word
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ir_q <= `BSC_NOP_WORD;
        end else if (ph.q_last) begin
            ir_q <= INSTR;
        end
    end

    // Two-cycle control: skip taken or call
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= BSC_EXEC;
        end else if (ph.q_last) begin
            case (state_q)
                BSC_EXEC: begin
                    if (two_cycle) begin
                        state_q <= BSC_FLUSH;
                    end
                end
                BSC_FLUSH: begin
                    state_q <= BSC_EXEC;
                end
                default: begin
                    state_q <= BSC_EXEC;
                end
            endcase
        end
    end

    // Register address presented in Q2 for the bit test
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            addr_q <= 7'h00;
        end else if (ph.q_first) begin
            addr_q <= reg_field(ir_q);
        end
    end

    // Program counter
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pc_q <= `BSC_PC_RST;
        end else if (ph.q_last) begin
            if (exec_now && op == BSC_OP_CALL) begin
                pc_q <= call_target(ir_q, PC_HIGH_LATCH);
            end else begin
                pc_q <= pc_next(pc_q);
            end
        end
    end

    // Stack push strobe, one clock wide
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            push_q <= 1'b0;
        end else begin
            push_q <= ph.q_last && exec_now && op == BSC_OP_CALL;
        end
    end

    // Return address, held until the next push
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            push_data_q <= `BSC_PC_RST;
        end else if (ph.q_last && exec_now && op == BSC_OP_CALL) begin
            push_data_q <= pc_next(pc_q);
        end
    end

    // No-op flag for the following cycle
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            nop_q <= 1'b0;
        end else if (ph.q_last) begin
            nop_q <= two_cycle;
        end
    end

    // Cycle boundary marker
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            end_q <= 1'b0;
        end else begin
            end_q <= ph.q_last;
        end
    end

    assign PC = pc_q;
    assign REG_ADDR = addr_q;
    assign STACK_PUSH = push_q;
    assign STACK_DATA = push_data_q;
    assign EXEC_NOP = nop_q;
    assign CYCLE_END = end_q;
endmodule // bsc_exec

// >>> inc/bsc_map.svh
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH
`define BSC_PC_W 13
`define BSC_OP_W 14
`define BSC_LIT_W 11
`define BSC_LIT_HI 10
`define BSC_PAGE_HI 4
`define BSC_PAGE_LO 3
`define BSC_PC_PAGE_HI 12
`define BSC_PC_PAGE_LO 11
`define BSC_BTSS_PAT 4'h7
`define BSC_CALL_PAT 3'h4
`define BSC_BIT_HI 9
`define BSC_BIT_LO 7
`define BSC_FADR_HI 6
`define BSC_OPC4_HI 13
`define BSC_OPC4_LO 10
`define BSC_OPC3_LO 11
`define BSC_NOP_WORD 14'h0000
`define BSC_PC_RST 13'h0000
`define BSC_PC_ONE 13'h0001
`define BSC_Q_ONE 2'h1
`define BSC_Q_LAST 2'h3
`endif

// >>> inc/bsc_pkg.sv
package bsc_pkg;
    typedef enum logic [1:0] {
        BSC_EXEC,
        BSC_FLUSH
    } bsc_state_t;

    typedef enum logic [1:0] {
        BSC_OP_OTHER,
        BSC_OP_SKIP,
        BSC_OP_CALL
    } bsc_op_t;
endpackage

// >>> inc/bsc_phase_if.sv
`timescale 1ns/1ns
interface bsc_phase_if;
    logic [1:0] q;
    logic q_first;
    logic q_last;
    modport gen (output q, output q_first, output q_last);
    modport use_side (input q, input q_first, input q_last);
endinterface // bsc_phase_if

// >>> design/bsc_phase.sv
`timescale 1ns/1ns
`include "bsc_map.svh"
module bsc_phase (
    input wire logic clk, // Core clock
    input wire logic resetn, // Async reset, active low
    bsc_phase_if.gen ph // Phase outputs
);
    logic [1:0] q_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q_q <= 2'h0;
        end else begin
            q_q <= q_q + `BSC_Q_ONE;
        end
    end

    assign ph.q = q_q;
    assign ph.q_first = (q_q == 2'h0);
    assign ph.q_last = (q_q == `BSC_Q_LAST);
endmodule // bsc_phase

// >>> tb/bsc_exec_sva.sv
`timescale 1ns/1ns
module bsc_chk (
    input wire logic CLK, // Clk
    input wire logic RESETN, // Rst
    input wire logic [13:0] INSTR, // Word
    input wire logic [7:0] REG_DATA, // Data
    input wire logic [7:0] PC_HIGH_LATCH, // Latch
    input wire logic [12:0] PC, // Pc
    input wire logic [12:0] STACK_DATA, // Ret
    input wire logic STACK_PUSH, // Push
    input wire logic EXEC_NOP, // Nop
    input wire logic CYCLE_END // End
);
    logic [13:0] w_q;
    // Word taken at the last Q4 edge
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) w_q <= 14'h0000;
        else if (CYCLE_END) w_q <= $past(INSTR);
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence s_skip(v);
        CYCLE_END ##3 (w_q[13:10] == 4'h7 && REG_DATA[w_q[9:7]] == v && !EXEC_NOP);
    endsequence
    sequence s_call;
        CYCLE_END ##3 (w_q[13:11] == 3'h4 && !EXEC_NOP);
    endsequence
    property p_skip_hit; s_skip(1'b1) |=> EXEC_NOP && !STACK_PUSH; endproperty
    a_skip_hit: assert property (p_skip_hit) else $error("skip lost");
    property p_skip_miss; s_skip(1'b0) |=> !EXEC_NOP; endproperty
    a_skip_miss: assert property (p_skip_miss) else $error("bad skip");
    property p_skip_len; s_skip(1'b1) |=> EXEC_NOP [*4] ##1 !EXEC_NOP; endproperty
    a_skip_len: assert property (p_skip_len) else $error("skip length");
    property p_call_pc;
        s_call |=> STACK_PUSH && STACK_DATA == $past(PC) + 13'h0001
            && PC == {$past(PC_HIGH_LATCH[4:3]), $past(w_q[10:0])};
    endproperty
    a_call_pc: assert property (p_call_pc) else $error("call target");
    property p_call_len; s_call |=> EXEC_NOP [*4] ##1 !(EXEC_NOP || STACK_PUSH); endproperty
    a_call_len: assert property (p_call_len) else $error("call length");
endmodule // bsc_chk
bind bsc_exec bsc_chk u_chk (.CLK, .RESETN, .INSTR, .REG_DATA, .PC_HIGH_LATCH, .PC,
    .STACK_DATA, .STACK_PUSH, .EXEC_NOP, .CYCLE_END);

// >>> tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic CLK = 1'b0, RESETN = 1'b0, STACK_PUSH, EXEC_NOP, CYCLE_END;
    logic [13:0] INSTR = 14'h2123;
    logic [7:0] REG_DATA = 8'h00, PC_HIGH_LATCH = 8'h18;
    logic [12:0] PC, STACK_DATA, pc = 13'h0001;
    logic [6:0] REG_ADDR;
    logic disc = 1'b0, hit, cl;
    logic [29:0] w;
    // Word, bit data, latch
    logic [29:0] rows [12] = '{{14'h2123, 8'h00, 8'h18}, {14'h1FFF, 8'hFF, 8'h18},
        {14'h1DA5, 8'hF7, 8'h18}, {14'h0000, 8'h00, 8'h08}, {14'h1FFF, 8'h80, 8'h08},
        {14'h27FF, 8'h00, 8'h08}, {14'h2001, 8'h00, 8'h08}, {14'h2000, 8'h00, 8'h10},
        {14'h2555, 8'h00, 8'h10}, {14'h1C00, 8'h01, 8'h10}, {14'h1C00, 8'h01, 8'h10},
        {14'h0000, 8'h00, 8'h10}};
    int failures = 0, num_checks = 0, n;
    always #25 CLK = ~CLK;
    bsc_exec dut (.CLK, .RESETN, .INSTR, .REG_DATA, .PC_HIGH_LATCH, .PC, .REG_ADDR,
        .STACK_PUSH, .STACK_DATA, .EXEC_NOP, .CYCLE_END);
    task automatic chk(input logic [12:0] g, input logic [12:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic print_verdict;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        print_verdict;
    end
    initial begin
        repeat (16) @(posedge CLK);
        @(negedge CLK) chk(PC | {EXEC_NOP, STACK_PUSH, CYCLE_END}, 13'h0000);
        @(posedge CLK) RESETN <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(posedge CLK);
            INSTR <= rows[i][29:16];
            {REG_DATA, PC_HIGH_LATCH} <= rows[i > 0 ? i - 1 : 0][15:0];
            n = 0;
            do @(negedge CLK); while (CYCLE_END !== 1'b1 && ++n < 9);
            chk(CYCLE_END, 1'b1);
            if (i == 0) continue;
            w = rows[i - 1];
            hit = !disc && w[29:26] == 4'h7 && w[8 + w[25:23]];
            cl = !disc && w[29:27] == 3'h4;
            chk(EXEC_NOP, hit || cl);
            chk(STACK_PUSH, cl);
            if (cl) chk(STACK_DATA, pc + 13'h0001);
            chk(REG_ADDR, w[22:16]);
            pc = cl ? {w[4:3], w[26:16]} : pc + 13'h0001;
            chk(PC, pc);
            disc = hit || cl;
        end
        @(posedge CLK) RESETN <= 1'b0;
        @(negedge CLK) chk(PC | {EXEC_NOP, STACK_PUSH}, 13'h0000);
        print_verdict;
    end
endmodule // tb_top
